// file: rtl/scf_pkg.sv
// Purpose: Shared constants for the four-phase slope compensation config block
// Assumes: Register port carries management-bus command codes and 16-bit words
// Notes:   Offsets are command codes; widths and positions per register layout
package scf_pkg;

	localparam int unsigned CMD_W          = 8;
	localparam int unsigned DATA_W         = 16;

	localparam logic [7:0]  CMD_SLEW_4P    = 8'hD4;
	localparam logic [7:0]  CMD_TIME_4P    = 8'hD5;

	localparam int unsigned CAP_LSB        = 6;
	localparam int unsigned CAP_W          = 3;
	localparam int unsigned CUR_LSB        = 0;
	localparam int unsigned CUR_W          = 6;
	localparam int unsigned SLEW_USED_W    = 9;
	localparam int unsigned LIMIT_LSB      = 0;
	localparam int unsigned LIMIT_W        = 8;

	localparam logic [15:0] SLEW_RESET     = 16'h0000;
	localparam logic [15:0] TIME_RESET     = 16'h0000;

	localparam logic [2:0]  FOUR_PHASES    = 3'h4;
	localparam int unsigned PHASE_W        = 3;

	// Ramp timer units
	localparam int unsigned LIMIT_STEP_NS  = 5;
	localparam int unsigned CLK_PERIOD_NS  = 40;
	localparam int unsigned ELAPSED_W      = 12;
	localparam logic [11:0] STEP_NS        = 12'(LIMIT_STEP_NS);
	localparam logic [11:0] TICK_NS        = 12'(CLK_PERIOD_NS);

	typedef enum logic [2:0] {
		SCF_IDLE = 3'b001,
		SCF_RAMP = 3'b010,
		SCF_HOLD = 3'b100
	} scf_state_e;

endpackage : scf_pkg

// file: rtl/scf_ramp_timer.sv
// Purpose: Times the slope compensation ramp and holds it when the limit is reached
// Assumes: Limit is counted in nanoseconds, advanced by one clock period per edge
// Notes:   Source stays on for ceil(limit*5/40) cycles, none when limit is zero
`timescale 1ns/1ps
module scf_ramp_timer
(
	input  wire logic     core_clk_i,
	input  wire logic     reset_n_i,
	scf_timer_if.timer    tmr
);

	scf_pkg::scf_state_e         state_q;
	scf_pkg::scf_state_e         state_d;
	logic [11:0]                 elapsed_q;
	logic [11:0]                 limit_ns;
	logic                        reached;

	// Limit in ns, 5 ns per count
	assign limit_ns = 12'({4'h0, tmr.limit} * scf_pkg::STEP_NS);
	assign reached  = (elapsed_q >= limit_ns);

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			scf_pkg::SCF_IDLE:
			begin
				if (tmr.start && tmr.active)
					state_d = scf_pkg::SCF_RAMP;
			end
			scf_pkg::SCF_RAMP:
			begin
				if (!tmr.active)
					state_d = scf_pkg::SCF_IDLE;
				else if (tmr.start)
					state_d = scf_pkg::SCF_RAMP;
				else if (reached)
					state_d = scf_pkg::SCF_HOLD;
			end
			scf_pkg::SCF_HOLD:
			begin
				if (!tmr.active)
					state_d = scf_pkg::SCF_IDLE;
				else if (tmr.start)
					state_d = scf_pkg::SCF_RAMP;
			end
			default:
				state_d = scf_pkg::SCF_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state_q <= scf_pkg::SCF_IDLE;
		else
			state_q <= state_d;
	end

	// Restart at each four-phase blanking end (start), advance while ramping
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			elapsed_q <= 12'h000;
		else if (tmr.start)
			elapsed_q <= 12'h000;
		else if (state_q == scf_pkg::SCF_RAMP && !reached)
			elapsed_q <= elapsed_q + scf_pkg::TICK_NS;
	end

	assign tmr.source_on = (state_q == scf_pkg::SCF_RAMP) && !reached;
	assign tmr.held      = (state_q == scf_pkg::SCF_HOLD);

endmodule : scf_ramp_timer

// file: rtl/scf_timer_if.sv
// Purpose: Carries ramp timer control and status between the config and timer modules
// Assumes: Single clock domain
// Notes:   start is a one-cycle pulse
`timescale 1ns/1ps
interface scf_timer_if;
	logic                 start;
	logic                 active;
	logic [7:0]           limit;
	logic                 source_on;
	logic                 held;

	modport ctrl  (output start, output active, output limit, input source_on, input held);
	modport timer (input start, input active, input limit, output source_on, output held);
endinterface : scf_timer_if

// file: rtl/scf_top.sv
// Purpose: Four-phase slope compensation slew and ramp-time configuration
// Assumes: Management-bus command port is decoded elsewhere into code, strobes, data
// Notes:   Analog ramp circuitry sits outside; this block drives its codes and controls
//
// Summary of operation
// - Slew settings reach the ramp only while four phases are active.
// - Bits 15 to 9 of the slew register ignore writes and read as zero.
// - Bits 8 to 6 of the slew register form the capacitor code, 1.85 pF per step.
// - Bits 5 to 0 of the slew register form the current code, 0.25 uA per step.
// - Ramp voltage is current times (period/4 minus blank) over (8 minus cap code) units.
// - The four-phase ramp is limited in time by a timer loaded from the ramp-time register.
// - On timer expiry the current source switches off and the ramp voltage is held.
// - The ramp-time limit is bits 7 to 0, 5 ns per count.
`timescale 1ns/1ps
module scf_top
(
	input  wire logic                 core_clk_i,
	input  wire logic                 reset_n_i,
	input  wire logic [7:0]           cmd_code_i,
	input  wire logic                 cmd_wr_i,
	input  wire logic                 cmd_rd_i,
	input  wire logic [15:0]          cmd_wdata_i,
	output logic      [15:0]          cmd_rdata_o,
	output logic                      cmd_hit_o,
	input  wire logic [2:0]           phase_count_i,
	input  wire logic                 blank_end_i,
	output logic      [2:0]           cap_code_o,
	output logic      [5:0]           current_code_o,
	output logic                      current_en_o,
	output logic                      ramp_hold_o,
	output logic                      four_phase_o
);

	logic [8:0]                       slew_q;
	logic [7:0]                       limit_q;
	logic [8:0]                       slew_live_q;
	logic [7:0]                       limit_live_q;
	logic                             four_phase;
	logic                             wr_slew;
	logic                             wr_time;
	logic                             hit;
	logic [15:0]                      rd_word;

	scf_timer_if                      tmr_if ();

	assign four_phase = (phase_count_i == scf_pkg::FOUR_PHASES);
	assign wr_slew    = cmd_wr_i && (cmd_code_i == scf_pkg::CMD_SLEW_4P);
	assign wr_time    = cmd_wr_i && (cmd_code_i == scf_pkg::CMD_TIME_4P);
	assign hit        = (cmd_code_i == scf_pkg::CMD_SLEW_4P) ||
	                    (cmd_code_i == scf_pkg::CMD_TIME_4P);

	// Slew register: only low 9 bits are stored
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			slew_q <= scf_pkg::SLEW_RESET[8:0];
		else if (wr_slew)
			slew_q <= cmd_wdata_i[8:0];
	end

	// Ramp-time register: only low 8 bits are stored
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			limit_q <= scf_pkg::TIME_RESET[7:0];
		else if (wr_time)
			limit_q <= cmd_wdata_i[7:0];
	end

	// Settings take effect at blanking end so a ramp never changes slope midway
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			slew_live_q  <= scf_pkg::SLEW_RESET[8:0];
			limit_live_q <= scf_pkg::TIME_RESET[7:0];
		end
		else if (blank_end_i && four_phase)
		begin
			slew_live_q  <= slew_q;
			limit_live_q <= limit_q;
		end
	end

	// Read path, reserved bits zero
	always_comb
	begin
		rd_word = 16'h0000;
		unique case (cmd_code_i)
			scf_pkg::CMD_SLEW_4P: rd_word = {7'h00, slew_q};
			scf_pkg::CMD_TIME_4P: rd_word = {8'h00, limit_q};
			default:              rd_word = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cmd_rdata_o <= 16'h0000;
			cmd_hit_o   <= 1'b0;
		end
		else if (cmd_rd_i)
		begin
			cmd_rdata_o <= rd_word;
			cmd_hit_o   <= hit;
		end
		else
			cmd_hit_o   <= 1'b0;
	end

	assign tmr_if.start  = blank_end_i && four_phase;
	assign tmr_if.active = four_phase;
	assign tmr_if.limit  = (blank_end_i && four_phase) ? limit_q : limit_live_q;

	scf_ramp_timer u_timer
	(
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.tmr        (tmr_if.timer)
	);

	// Codes to the analog ramp; V = I*(Tsw/4 - Tblank)/((8 - cap)*Cunit)
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cap_code_o     <= 3'h0;
			current_code_o <= 6'h00;
			four_phase_o   <= 1'b0;
		end
		else if (four_phase)
		begin
			cap_code_o     <= slew_live_q[scf_pkg::CAP_LSB +: scf_pkg::CAP_W];
			current_code_o <= slew_live_q[scf_pkg::CUR_LSB +: scf_pkg::CUR_W];
			four_phase_o   <= 1'b1;
		end
		else
		begin
			cap_code_o     <= 3'h0;
			current_code_o <= 6'h00;
			four_phase_o   <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			current_en_o <= 1'b0;
			ramp_hold_o  <= 1'b0;
		end
		else
		begin
			current_en_o <= tmr_if.source_on;
			ramp_hold_o  <= tmr_if.held;
		end
	end

endmodule : scf_top

// file: testbench/scf_top_asserts.sv
// Purpose: Port-level checks of the four-phase ramp config block
// Assumes: One clock, async active-low reset
// Notes:   Bound to scf_top after the module
`timescale 1ns/1ps
module scf_top_asserts
(
	input wire logic        core_clk_i,
	input wire logic        reset_n_i,
	input wire logic [7:0]  cmd_code_i,
	input wire logic        cmd_rd_i,
	input wire logic [15:0] cmd_rdata_o,
	input wire logic        cmd_hit_o,
	input wire logic [2:0]  phase_count_i,
	input wire logic        blank_end_i,
	input wire logic [2:0]  cap_code_o,
	input wire logic [5:0]  current_code_o,
	input wire logic        current_en_o,
	input wire logic        ramp_hold_o,
	input wire logic        four_phase_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [5:0] en_cnt_q;
	logic       mapped;
	assign mapped = cmd_code_i == 8'hD4 || cmd_code_i == 8'hD5;
	// Length of one unbroken source-on run
	always_ff @(posedge core_clk_i or negedge reset_n_i)
		if (!reset_n_i)
			en_cnt_q <= 6'h00;
		else if (blank_end_i || !current_en_o)
			en_cnt_q <= 6'h00;
		else
			en_cnt_q <= en_cnt_q + 6'h01;
	sequence s_start;
		blank_end_i && phase_count_i == 3'h4;
	endsequence
	sequence s_settle;
		phase_count_i == 3'h4 && !blank_end_i;
	endsequence
	a_hit_mapped: assert property (cmd_rd_i && mapped |=> cmd_hit_o)
		else $error("no hit on mapped read");
	a_miss_unmapped: assert property (cmd_rd_i && !mapped |=> !cmd_hit_o)
		else $error("hit on unmapped read");
	a_slew_resv_zero: assert property (cmd_rd_i && cmd_code_i == 8'hD4
		|=> cmd_rdata_o[15:9] == 7'h00) else $error("slew reserved bits set");
	a_time_resv_zero: assert property (cmd_rd_i && cmd_code_i == 8'hD5
		|=> cmd_rdata_o[15:8] == 8'h00) else $error("time reserved bits set");
	a_codes_off: assert property (phase_count_i != 3'h4 [*3] |-> cap_code_o == 3'h0
		&& current_code_o == 6'h00 && !current_en_o) else $error("active outside four phases");
	a_start_ramp: assert property (s_start ##1 s_settle |=> (current_en_o or (##1 ramp_hold_o)))
		else $error("no ramp after blanking end");
	a_on_time_limit: assert property (en_cnt_q <= 6'h22)
		else $error("source on too long");
	a_hold_stays: assert property (ramp_hold_o && four_phase_o && phase_count_i == 3'h4
		&& !blank_end_i && !$past(blank_end_i) |=> ramp_hold_o) else $error("hold released early");
endmodule : scf_top_asserts

bind scf_top scf_top_asserts scf_top_asserts_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
	.cmd_code_i(cmd_code_i), .cmd_rd_i(cmd_rd_i), .cmd_rdata_o(cmd_rdata_o),
	.cmd_hit_o(cmd_hit_o), .phase_count_i(phase_count_i), .blank_end_i(blank_end_i),
	.cap_code_o(cap_code_o), .current_code_o(current_code_o), .current_en_o(current_en_o),
	.ramp_hold_o(ramp_hold_o), .four_phase_o(four_phase_o));

// file: testbench/tb.sv
// Purpose: Self-checking bench for the four-phase ramp config block
// Assumes: Inputs driven 1 ns after the rising edge
// Notes:   Ramp length expected as ceil(limit*5/40) cycles
`timescale 1ns/1ps
module tb;
	logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, blank = 1'b0;
	logic [7:0]  code = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic [2:0]  ph = 3'h0;
	logic [15:0] rdata;
	logic        hit, en, hold, four;
	logic [2:0]  cap;
	logic [5:0]  cur;
	int          num_errors = 0;
	int          n_tests = 0;
	scf_top scf_top_i (.core_clk_i(clk), .reset_n_i(rst_n), .cmd_code_i(code), .cmd_wr_i(wr),
		.cmd_rd_i(rd), .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_hit_o(hit),
		.phase_count_i(ph), .blank_end_i(blank), .cap_code_o(cap), .current_code_o(cur),
		.current_en_o(en), .ramp_hold_o(hold), .four_phase_o(four));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr_reg(input logic [7:0] c, input logic [15:0] d);
		code = c;
		wdata = d;
		wr = 1'b1;
		@(posedge clk) #1;
		wr = 1'b0;
		@(posedge clk) #1;
	endtask : wr_reg
	task rd_reg(input logic [7:0] c, input logic [15:0] exp, input logic exp_hit);
		code = c;
		rd = 1'b1;
		@(posedge clk) #1;
		rd = 1'b0;
		chk(rdata, exp);
		chk({15'h0, hit}, {15'h0, exp_hit});
		@(posedge clk) #1;
	endtask : rd_reg
	// Pulse a blanking end, count source-on cycles
	task run_ramp(output int n);
		blank = 1'b1;
		@(posedge clk) #1;
		blank = 1'b0;
		n = 0;
		repeat (40)
		begin
			@(posedge clk) #1;
			n += int'(en === 1'b1);
		end
	endtask : run_ramp
	task t_regs;
		rd_reg(8'hD4, 16'h0000, 1'b1);
		rd_reg(8'hD5, 16'h0000, 1'b1);
		wr_reg(8'hD4, 16'hFFFF);
		rd_reg(8'hD4, 16'h01FF, 1'b1);
		wr_reg(8'hD5, 16'hFFFF);
		rd_reg(8'hD5, 16'h00FF, 1'b1);
		rd_reg(8'hD6, 16'h0000, 1'b0);
		$display("register test done");
	endtask : t_regs
	task t_ramp(input logic [15:0] slew, input logic [7:0] lim);
		int n;
		ph = 3'h4;
		wr_reg(8'hD4, slew);
		wr_reg(8'hD5, {8'h00, lim});
		run_ramp(n);
		chk(16'(n), 16'((int'(lim) * 5 + 39) / 40));
		chk({15'h0, hold}, 16'h0001);
		chk({13'h0, cap}, {13'h0, slew[8:6]});
		chk({10'h0, cur}, {10'h0, slew[5:0]});
		chk({15'h0, four}, 16'h0001);
		$display("ramp test done, limit %h", lim);
	endtask : t_ramp
	task t_phase;
		int n;
		ph = 3'h3;
		repeat (3) @(posedge clk) #1;
		wr_reg(8'hD4, 16'h01FF);
		run_ramp(n);
		chk(16'(n), 16'h0000);
		chk({7'h0, four, cap, cur}, 16'h0000);
		chk({15'h0, hold}, 16'h0000);
		ph = 3'h4;
		repeat (2) @(posedge clk) #1;
		chk({13'h0, cap}, 16'h0001);
		chk({10'h0, cur}, 16'h0000);
		$display("phase test done");
	endtask : t_phase
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	initial
	begin
		forever #20 clk = ~clk;
	end
	initial
	begin
		#100000;
		num_errors++;
		end_sim();
	end
	initial
	begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		@(posedge clk) #1;
		t_regs();
		t_ramp(16'h0145, 8'h10);
		t_ramp(16'hFFFF, 8'hFF);
		t_ramp(16'h0040, 8'h01);
		t_phase();
		t_ramp(16'h0000, 8'h00);
		end_sim();
	end
endmodule : tb
